// >>> core/tcp_offload_test_sequencer.sv
// Test register block of the offload engine: init sequencing, commands, pattern gen and check.
// Assumes the TCP core reports connection state and accepts beats with a ready handshake.
`timescale 1ns/1ps
module tcp_offload_test_sequencer (
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_in,
    input  wire logic [7:0]            addr_in,
    input  wire logic [31:0]           wdata_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    output logic [31:0]                rdata_out,
    input  wire tcp_test_pkg::arp_rx_s arp_rx_in,
    output logic                       arp_request_out,
    output logic                       arp_reply_out,
    output logic [47:0]                target_hw_addr_out,
    output logic                       engine_reset_out,
    output tcp_test_pkg::conn_cmd_s    conn_cmd_out,
    input  wire logic                  conn_on_in,
    output tcp_test_pkg::tx_beat_s     tx_beat_out,
    input  wire logic                  tx_ready_in,
    input  wire tcp_test_pkg::rx_beat_s rx_beat_in
);

    tcp_test_pkg::init_state_e init_st_q, init_st_d;
    logic [1:0]  mode_q, mode_d;
    logic        eng_rst_q, eng_rst_d;
    logic [47:0] fixed_addr_q, fixed_addr_d;
    logic [47:0] target_q, target_d;
    logic        arp_req_q, arp_req_d;
    logic        arp_rep_q, arp_rep_d;
    tcp_test_pkg::conn_cmd_s cmd_q, cmd_d;
    logic [31:0] tx_total_q, tx_total_d;
    logic [31:0] pkt_size_q, pkt_size_d;
    logic        push_mode_q, push_mode_d;
    logic        tx_run_q, tx_run_d;
    logic [31:0] tx_len_q, tx_len_d;
    logic [31:0] pkt_cnt_q, pkt_cnt_d;
    tcp_test_pkg::tx_beat_s beat_q, beat_d;
    logic        verify_q, verify_d;
    logic [31:0] rx_len_q, rx_len_d;
    logic        fail_q, fail_d;
    logic [31:0] rdata_q, rdata_d;
    logic        init_done;
    logic        rx_mismatch;

    // True when a write strobe hits the given offset
    function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
        wr_hit = wr && (a == off);
    endfunction : wr_hit

    assign init_done = (init_st_q == tcp_test_pkg::INIT_DONE);
    assign rx_mismatch = rx_beat_in.valid && (rx_beat_in.data != {2'h0, rx_len_q[31:2]});

    // Next state of registers, init sequencer, generator and checker
    always_comb begin
        init_st_d = init_st_q;
        mode_d = mode_q;
        eng_rst_d = eng_rst_q;
        fixed_addr_d = fixed_addr_q;
        target_d = target_q;
        arp_req_d = 1'b0;
        arp_rep_d = 1'b0;
        cmd_d = '0;
        tx_total_d = tx_total_q;
        pkt_size_d = pkt_size_q;
        push_mode_d = push_mode_q;
        tx_run_d = tx_run_q;
        tx_len_d = tx_len_q;
        pkt_cnt_d = pkt_cnt_q;
        beat_d = beat_q;
        verify_d = verify_q;
        rx_len_d = rx_len_q;
        fail_d = fail_q;
        // Parameter writes
        if (wr_hit(wr_in, addr_in, tcp_test_pkg::OFF_ENGINE_RESET)) begin
            eng_rst_d = wdata_in[tcp_test_pkg::BIT_ENGINE_RESET];
        end
        if (wr_hit(wr_in, addr_in, tcp_test_pkg::OFF_INIT_MODE)) begin
            mode_d = wdata_in[1:0];
        end
        if (wr_hit(wr_in, addr_in, tcp_test_pkg::OFF_TARGET_HW_LOW)) begin
            fixed_addr_d[31:0] = wdata_in;
        end
        if (wr_hit(wr_in, addr_in, tcp_test_pkg::OFF_TARGET_HW_HIGH)) begin
            fixed_addr_d[47:32] = wdata_in[15:0];
        end
        if (wr_hit(wr_in, addr_in, tcp_test_pkg::OFF_TX_TOTAL_SIZE)) begin
            tx_total_d = wdata_in;
        end
        if (wr_hit(wr_in, addr_in, tcp_test_pkg::OFF_TX_PACKET_SIZE)) begin
            pkt_size_d = wdata_in;
        end
        if (wr_hit(wr_in, addr_in, tcp_test_pkg::OFF_TX_PUSH_MODE)) begin
            push_mode_d = wdata_in[0];
        end
        // Engine commands pass only once initialised
        if (wr_hit(wr_in, addr_in, tcp_test_pkg::OFF_ENGINE_COMMAND) && init_done) begin
            cmd_d.active_open = (wdata_in[1:0] == tcp_test_pkg::CMD_ACTIVE_OPEN);
            cmd_d.passive_open = (wdata_in[1:0] == tcp_test_pkg::CMD_PASSIVE_OPEN);
            cmd_d.active_close = (wdata_in[1:0] == tcp_test_pkg::CMD_ACTIVE_CLOSE);
        end
        // Initialisation sequence per mode
        unique case (init_st_q)
            tcp_test_pkg::INIT_IDLE: begin
                if (!eng_rst_q) begin
                    if (mode_q == tcp_test_pkg::MODE_CLIENT) begin
                        init_st_d = tcp_test_pkg::INIT_ASK;
                        arp_req_d = 1'b1;
                    end else if (mode_q == tcp_test_pkg::MODE_SERVER) begin
                        init_st_d = tcp_test_pkg::INIT_WAIT;
                    end else begin
                        target_d = fixed_addr_q;
                        init_st_d = tcp_test_pkg::INIT_DONE;
                    end
                end
            end
            tcp_test_pkg::INIT_ASK: begin
                init_st_d = tcp_test_pkg::INIT_WAIT;
            end
            tcp_test_pkg::INIT_WAIT: begin
                if (arp_rx_in.valid && (mode_q == tcp_test_pkg::MODE_CLIENT)
                    && !arp_rx_in.is_request) begin
                    target_d = arp_rx_in.hw_addr;
                    init_st_d = tcp_test_pkg::INIT_DONE;
                end else if (arp_rx_in.valid && (mode_q == tcp_test_pkg::MODE_SERVER)
                    && arp_rx_in.is_request) begin
                    target_d = arp_rx_in.hw_addr;
                    arp_rep_d = 1'b1;
                    init_st_d = tcp_test_pkg::INIT_DONE;
                end
            end
            tcp_test_pkg::INIT_DONE: begin
                init_st_d = init_st_q;
            end
        endcase
        // Pattern generator
        if (wr_hit(wr_in, addr_in, tcp_test_pkg::OFF_TX_COMMAND)) begin
            if (wdata_in[tcp_test_pkg::BIT_CLEAR]) begin
                tx_len_d = '0;
                pkt_cnt_d = '0;
            end
            if (wdata_in[tcp_test_pkg::BIT_TX_SEND] && init_done) begin
                tx_run_d = 1'b1;
            end
        end
        if (beat_q.valid && tx_ready_in) begin
            beat_d.valid = 1'b0;
        end
        if (tx_run_q && conn_on_in && (!beat_q.valid || tx_ready_in)) begin
            if (tx_len_q >= tx_total_q) begin
                tx_run_d = 1'b0;
            end else begin
                beat_d.valid = 1'b1;
                beat_d.data = {2'h0, tx_len_q[31:2]};
                beat_d.push = push_mode_q && ((pkt_cnt_q + tcp_test_pkg::BYTES_PER_BEAT
                    >= pkt_size_q) || (tx_len_q + tcp_test_pkg::BYTES_PER_BEAT >= tx_total_q));
                tx_len_d = tx_len_q + tcp_test_pkg::BYTES_PER_BEAT;
                pkt_cnt_d = beat_d.push ? '0 : pkt_cnt_q + tcp_test_pkg::BYTES_PER_BEAT;
            end
        end
        // Pattern checker; a mismatch in the clear cycle still sets the flag
        if (wr_hit(wr_in, addr_in, tcp_test_pkg::OFF_RX_COMMAND)) begin
            verify_d = wdata_in[tcp_test_pkg::BIT_VERIFY_EN];
            if (wdata_in[tcp_test_pkg::BIT_CLEAR]) begin
                rx_len_d = '0;
                fail_d = 1'b0;
            end
        end
        if (rx_beat_in.valid) begin
            rx_len_d = rx_len_d + tcp_test_pkg::BYTES_PER_BEAT;
        end
        if (verify_q && rx_mismatch) begin
            fail_d = 1'b1;
        end
        // Engine held in reset: restart init, clear generator and checker
        if (eng_rst_q) begin
            init_st_d = tcp_test_pkg::INIT_IDLE;
            tx_run_d = 1'b0;
            tx_len_d = '0;
            pkt_cnt_d = '0;
            beat_d = '0;
            rx_len_d = '0;
            fail_d = 1'b0;
        end
    end

    // Read path: data stand only in the cycle after the strobe
    always_comb begin
        rdata_d = '0;
        if (rd_in) begin
            unique case (addr_in)
                tcp_test_pkg::OFF_ENGINE_RESET:   rdata_d = {31'h0, eng_rst_q};
                tcp_test_pkg::OFF_ENGINE_STATUS:  rdata_d = {30'h0, conn_on_in, init_done};
                tcp_test_pkg::OFF_INIT_MODE:      rdata_d = {30'h0, mode_q};
                tcp_test_pkg::OFF_TARGET_HW_LOW:  rdata_d = target_q[31:0];
                tcp_test_pkg::OFF_TARGET_HW_HIGH: rdata_d = {16'h0, target_q[47:32]};
                tcp_test_pkg::OFF_TX_TOTAL_SIZE:  rdata_d = tx_total_q;
                tcp_test_pkg::OFF_TX_PACKET_SIZE: rdata_d = pkt_size_q;
                tcp_test_pkg::OFF_TX_PUSH_MODE:   rdata_d = {31'h0, push_mode_q};
                tcp_test_pkg::OFF_TX_COMMAND:     rdata_d = {31'h0, tx_run_q};
                tcp_test_pkg::OFF_TX_LENGTH:      rdata_d = tx_len_q;
                tcp_test_pkg::OFF_RX_COMMAND:     rdata_d = {31'h0, verify_q};
                tcp_test_pkg::OFF_RX_LENGTH:      rdata_d = rx_len_q;
                tcp_test_pkg::OFF_RX_STATUS:      rdata_d = {23'h0, fail_q, 8'h0};
                default:                          rdata_d = '0;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            init_st_q <= tcp_test_pkg::INIT_IDLE;
            mode_q <= tcp_test_pkg::MODE_CLIENT;
            eng_rst_q <= tcp_test_pkg::ENGINE_RESET_INIT;
            fixed_addr_q <= '0;
            target_q <= '0;
            arp_req_q <= 1'b0;
            arp_rep_q <= 1'b0;
            cmd_q <= '0;
            tx_total_q <= '0;
            pkt_size_q <= tcp_test_pkg::TX_PACKET_SIZE_INIT;
            push_mode_q <= 1'b0;
            tx_run_q <= 1'b0;
            tx_len_q <= '0;
            pkt_cnt_q <= '0;
            beat_q <= '0;
            verify_q <= 1'b0;
            rx_len_q <= '0;
            fail_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            init_st_q <= init_st_d;
            mode_q <= mode_d;
            eng_rst_q <= eng_rst_d;
            fixed_addr_q <= fixed_addr_d;
            target_q <= target_d;
            arp_req_q <= arp_req_d;
            arp_rep_q <= arp_rep_d;
            cmd_q <= cmd_d;
            tx_total_q <= tx_total_d;
            pkt_size_q <= pkt_size_d;
            push_mode_q <= push_mode_d;
            tx_run_q <= tx_run_d;
            tx_len_q <= tx_len_d;
            pkt_cnt_q <= pkt_cnt_d;
            beat_q <= beat_d;
            verify_q <= verify_d;
            rx_len_q <= rx_len_d;
            fail_q <= fail_d;
            rdata_q <= rdata_d;
        end
    end

    // Outputs
    assign rdata_out = rdata_q;
    assign arp_request_out = arp_req_q;
    assign arp_reply_out = arp_rep_q;
    assign target_hw_addr_out = target_q;
    assign engine_reset_out = eng_rst_q;
    assign conn_cmd_out = cmd_q;
    assign tx_beat_out = beat_q;

    // Checks
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    a_reset_holds_init: assert property (eng_rst_q |=> !init_done)
        else $error("init done while engine reset held");
    a_release_starts_init: assert property ($fell(eng_rst_q) |=> init_st_q != tcp_test_pkg::INIT_IDLE)
        else $error("init did not start on reset release");
    a_reset_clears_gen: assert property (eng_rst_q |=> tx_len_q == 32'h0 && !fail_q)
        else $error("generator or checker not cleared by engine reset");
    a_client_sends_request: assert property ($fell(eng_rst_q) && mode_q == tcp_test_pkg::MODE_CLIENT
        |=> arp_req_q ##1 !arp_req_q)
        else $error("client init sent no single request");
    a_client_takes_reply: assert property (init_st_q == tcp_test_pkg::INIT_WAIT && !eng_rst_q
        && mode_q == tcp_test_pkg::MODE_CLIENT && arp_rx_in.valid && !arp_rx_in.is_request
        |=> target_q == $past(arp_rx_in.hw_addr) && init_done)
        else $error("client did not take reply address");
    a_server_answers: assert property (init_st_q == tcp_test_pkg::INIT_WAIT && !eng_rst_q
        && mode_q == tcp_test_pkg::MODE_SERVER && arp_rx_in.valid && arp_rx_in.is_request
        |=> arp_rep_q && target_q == $past(arp_rx_in.hw_addr))
        else $error("server did not answer request");
    a_server_no_request: assert property (mode_q == tcp_test_pkg::MODE_SERVER |-> !arp_req_q)
        else $error("server sent a request");
    a_verify_sets_fail: assert property (verify_q && rx_mismatch && !eng_rst_q |=> fail_q)
        else $error("mismatch did not set fail flag");
    a_fail_bit_read: assert property (rd_in && addr_in == tcp_test_pkg::OFF_RX_STATUS
        |=> rdata_out[8] == $past(fail_q))
        else $error("status bit eight differs from fail flag");

    c_client_init: cover property (arp_req_q ##[1:50] init_done);
    c_server_init: cover property (arp_rep_q);
    c_send_done: cover property (tx_run_q ##1 !tx_run_q && !eng_rst_q);
    c_verify_fail: cover property ($rose(fail_q));

endmodule : tcp_offload_test_sequencer

// >>> core/tcp_test_pkg.sv
// Constants, types and register map of the offload engine test register block.
// Assumes one 20 MHz clock and a plain strobe register port with one-cycle read latency.
package tcp_test_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_ENGINE_RESET = 8'h00;
    localparam logic [7:0] OFF_ENGINE_STATUS = 8'h04;
    localparam logic [7:0] OFF_ENGINE_COMMAND = 8'h08;
    localparam logic [7:0] OFF_INIT_MODE = 8'h0c;
    localparam logic [7:0] OFF_TARGET_HW_LOW = 8'h10;
    localparam logic [7:0] OFF_TARGET_HW_HIGH = 8'h14;
    localparam logic [7:0] OFF_TX_TOTAL_SIZE = 8'h18;
    localparam logic [7:0] OFF_TX_PACKET_SIZE = 8'h1c;
    localparam logic [7:0] OFF_TX_PUSH_MODE = 8'h20;
    localparam logic [7:0] OFF_TX_COMMAND = 8'h24;
    localparam logic [7:0] OFF_TX_LENGTH = 8'h28;
    localparam logic [7:0] OFF_RX_COMMAND = 8'h2c;
    localparam logic [7:0] OFF_RX_LENGTH = 8'h30;
    localparam logic [7:0] OFF_RX_STATUS = 8'h34;

    // Field positions
    localparam int BIT_ENGINE_RESET = 0;
    localparam int BIT_INIT_DONE = 0;
    localparam int BIT_CONN_ON = 1;
    localparam int BIT_TX_SEND = 0;
    localparam int BIT_CLEAR = 1;
    localparam int BIT_VERIFY_EN = 0;
    localparam int BIT_VERIFY_FAIL = 8;

    // Values after reset, and bytes per data beat
    localparam logic ENGINE_RESET_INIT = 1'b1;
    localparam logic [31:0] TX_PACKET_SIZE_INIT = 32'h0000_0400;
    localparam logic [31:0] BYTES_PER_BEAT = 32'h0000_0004;

    // Engine commands written to the command register
    localparam logic [1:0] CMD_ACTIVE_OPEN = 2'h1;
    localparam logic [1:0] CMD_PASSIVE_OPEN = 2'h2;
    localparam logic [1:0] CMD_ACTIVE_CLOSE = 2'h3;

    typedef enum logic [1:0] {
        MODE_CLIENT = 2'b00,
        MODE_SERVER = 2'b01,
        MODE_FIXED  = 2'b10
    } init_mode_e;

    typedef enum logic [1:0] {
        INIT_IDLE = 2'b00,
        INIT_ASK  = 2'b01,
        INIT_WAIT = 2'b10,
        INIT_DONE = 2'b11
    } init_state_e;

    typedef struct packed {
        logic        valid;
        logic        is_request;
        logic [47:0] hw_addr;
    } arp_rx_s;

    typedef struct packed {
        logic active_open;
        logic passive_open;
        logic active_close;
    } conn_cmd_s;

    typedef struct packed {
        logic        valid;
        logic        push;
        logic [31:0] data;
    } tx_beat_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } rx_beat_s;

endpackage : tcp_test_pkg

// >>> dv/tcp_core_model.sv
// Behavioural model of the TCP core and peer that stands beyond the test register block.
// Assumes the block's clock and synchronous active-high reset; the bench steers rx traffic.
`timescale 1ns/1ps
module tcp_core_model #(
    parameter logic [47:0] PEER_HW = 48'h0200_1122_3344, // Arbitrary peer address
    parameter logic [47:0] ASK_HW  = 48'h0200_5566_7788  // Arbitrary requester address
) (
    input  wire logic                    clk_sys_in,
    input  wire logic                    rst_in,
    input  wire logic                    arp_request_in,
    input  wire logic                    arp_reply_in,
    input  wire logic                    arp_ask_in,
    input  wire tcp_test_pkg::conn_cmd_s conn_cmd_in,
    input  wire tcp_test_pkg::tx_beat_s  tx_beat_in,
    input  wire logic                    rx_go_in,
    input  wire logic [7:0]              rx_words_in,
    input  wire logic                    rx_bad_in,
    input  wire logic                    rx_close_in,
    output tcp_test_pkg::arp_rx_s        arp_rx_out,
    output logic                         conn_on_out,
    output logic                         tx_ready_out,
    output tcp_test_pkg::rx_beat_s       rx_beat_out,
    output logic [7:0]                   tx_beats_out,
    output logic [7:0]                   tx_bad_out,
    output logic [7:0]                   replies_out,
    output logic [7:0]                   tx_push_out
);
    logic [2:0] open_q, shut_q, arp_q;
    logic [7:0] left_q, idx_q;
    logic       close_q, bad_q;

    // Connection delays, address packets, tx acceptance and peer rx traffic
    always_ff @(posedge clk_sys_in) begin
        arp_rx_out <= '0;
        rx_beat_out <= {1'b0, 32'hffff_ffff ^ {24'h0, idx_q}}; // Idle data is the inverted word index, held between bursts
        open_q <= {open_q[1:0], conn_cmd_in.active_open | conn_cmd_in.passive_open};
        shut_q <= {shut_q[1:0], conn_cmd_in.active_close};
        arp_q <= {arp_q[1:0], arp_request_in};
        if (rst_in) begin
            conn_on_out <= 1'b0;
            tx_ready_out <= 1'b0;
            tx_beats_out <= 8'h00;
            tx_bad_out <= 8'h00;
            replies_out <= 8'h00;
            tx_push_out <= 8'h00;
            left_q <= 8'h00;
            idx_q <= 8'h00;
        end else begin
            tx_ready_out <= ~tx_ready_out; // Half-rate acceptance stalls the generator
            if (open_q[2]) conn_on_out <= 1'b1;
            if (shut_q[2]) conn_on_out <= 1'b0;
            if (arp_q[2]) arp_rx_out <= {1'b1, 1'b0, PEER_HW}; // Answer the request
            if (arp_ask_in) arp_rx_out <= {1'b1, 1'b1, ASK_HW}; // Ask the engine
            if (arp_reply_in) replies_out <= replies_out + 8'h01;
            if (!conn_on_out) tx_beats_out <= 8'h00;
            if (tx_beat_in.valid && tx_ready_out) begin
                tx_beats_out <= tx_beats_out + 8'h01;
                tx_push_out <= tx_push_out + {7'h0, tx_beat_in.push}; // Pushes seen
                if (tx_beat_in.data !== {24'h0, tx_beats_out}) tx_bad_out <= tx_bad_out + 8'h01;
            end
            if (rx_go_in) begin
                left_q <= rx_words_in;
                idx_q <= 8'h00;
                bad_q <= rx_bad_in;
                close_q <= rx_close_in;
            end else if (left_q != 8'h00) begin
                rx_beat_out <= {1'b1, 24'h0, idx_q ^ {7'h0, bad_q & (left_q == 8'h01)}};
                idx_q <= idx_q + 8'h01;
                left_q <= left_q - 8'h01;
                if (left_q == 8'h01 && close_q) conn_on_out <= 1'b0; // Peer closes
            end
        end
    end
endmodule : tcp_core_model

// >>> dv/testbench.sv
// Self-checking bench: register-level test sequences against the core model.
// Assumes a 20 MHz clock and a one-cycle read latency on the register port.
`timescale 1ns/1ps
module testbench;
    localparam logic [47:0] PEER = 48'h0200_1122_3344;
    localparam logic [47:0] ASK  = 48'h0200_5566_7788;
    localparam logic [47:0] FIX  = 48'h0200_99aa_bbcc;
    logic                    clk_sys_in = 1'b0;
    logic                    rst_in = 1'b1;
    logic [7:0]              addr_in = 8'h00;
    logic [31:0]             wdata_in = 32'h0;
    logic                    wr_in = 1'b0;
    logic                    rd_in = 1'b0;
    logic [31:0]             rdata_out, v;
    tcp_test_pkg::arp_rx_s   arp_rx;
    tcp_test_pkg::conn_cmd_s conn_cmd;
    tcp_test_pkg::tx_beat_s  tx_beat;
    tcp_test_pkg::rx_beat_s  rx_beat;
    logic                    arp_req, arp_rep, eng_rst, conn_on, tx_ready;
    logic [47:0]             target_hw;
    logic                    arp_ask = 1'b0;
    logic                    rx_go = 1'b0;
    logic [7:0]              rx_words = 8'h00;
    logic                    rx_bad = 1'b0;
    logic                    rx_close = 1'b0;
    logic [7:0]              tx_beats, tx_bad, replies, tx_push;
    int                      failures = 0;
    int                      tests_run = 0;

    // Clock
    always #25 clk_sys_in = ~clk_sys_in;

    tcp_offload_test_sequencer u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .arp_rx_in(arp_rx), .arp_request_out(arp_req),
        .arp_reply_out(arp_rep), .target_hw_addr_out(target_hw),
        .engine_reset_out(eng_rst), .conn_cmd_out(conn_cmd), .conn_on_in(conn_on),
        .tx_beat_out(tx_beat), .tx_ready_in(tx_ready), .rx_beat_in(rx_beat));

    tcp_core_model #(.PEER_HW(PEER), .ASK_HW(ASK)) u_core (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .arp_request_in(arp_req), .arp_reply_in(arp_rep),
        .arp_ask_in(arp_ask), .conn_cmd_in(conn_cmd), .tx_beat_in(tx_beat),
        .rx_go_in(rx_go), .rx_words_in(rx_words), .rx_bad_in(rx_bad),
        .rx_close_in(rx_close), .arp_rx_out(arp_rx), .conn_on_out(conn_on),
        .tx_ready_out(tx_ready), .rx_beat_out(rx_beat), .tx_beats_out(tx_beats),
        .tx_bad_out(tx_bad), .replies_out(replies), .tx_push_out(tx_push));

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : rd

    // Bounded poll of a masked register value
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] w);
        logic [31:0] d;
        d = 32'h0;
        for (int i = 0; i < 2000; i++) begin
            rd(a, d);
            if ((d & m) === w) break;
        end
        check(d & m, w);
        if ((d & m) !== w) test_done();
    endtask : poll

    // Engine reset, parameters, release, then wait for init done
    task automatic init(input logic [1:0] mode, input logic [47:0] hw);
        wr(8'h00, 32'h1);
        #1 check({31'h0, eng_rst}, 32'h1);
        wr(8'h0c, {30'h0, mode});
        wr(8'h10, hw[31:0]);
        wr(8'h14, {16'h0, hw[47:32]});
        wr(8'h00, 32'h0);
        if (mode == tcp_test_pkg::MODE_SERVER) begin
            repeat (3) @(posedge clk_sys_in);
            arp_ask <= 1'b1;
            @(posedge clk_sys_in);
            arp_ask <= 1'b0;
        end
        poll(8'h04, 32'h1, 32'h1);
    endtask : init

    task automatic rx_send(input logic [7:0] n, input logic bad, input logic cls);
        @(posedge clk_sys_in);
        rx_go <= 1'b1;
        rx_words <= n;
        rx_bad <= bad;
        rx_close <= cls;
        @(posedge clk_sys_in);
        rx_go <= 1'b0;
    endtask : rx_send

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(8'h00, v); check(v, 32'h1);
        rd(8'h1c, v); check(v, tcp_test_pkg::TX_PACKET_SIZE_INIT);
        rd(8'h04, v); check(v, 32'h0);
        rd(8'hfc, v); check(v, 32'h0);
        init(tcp_test_pkg::MODE_CLIENT, FIX);
        rd(8'h10, v); check(v, PEER[31:0]);
        rd(8'h14, v); check(v, {16'h0, PEER[47:32]});
        init(tcp_test_pkg::MODE_SERVER, FIX);
        rd(8'h10, v); check(v, ASK[31:0]);
        check({24'h0, replies}, 32'h1);
        init(tcp_test_pkg::MODE_FIXED, FIX);
        check(target_hw[31:0], FIX[31:0]);
        rd(8'h14, v); check(v, {16'h0, FIX[47:32]});
        wr(8'h18, 32'd32);
        wr(8'h1c, 32'd8);
        wr(8'h20, 32'h1);
        wr(8'h08, {30'h0, tcp_test_pkg::CMD_ACTIVE_OPEN});
        poll(8'h04, 32'h2, 32'h2);
        wr(8'h24, 32'h1);
        poll(8'h28, 32'hffff_ffff, 32'd32);
        // Let the last pending beat be accepted before counting
        repeat (2) @(posedge clk_sys_in);
        #1 check({24'h0, tx_beats}, 32'd8);
        check({24'h0, tx_push}, 32'd4);
        wr(8'h08, {30'h0, tcp_test_pkg::CMD_ACTIVE_CLOSE});
        poll(8'h04, 32'h2, 32'h0);
        init(tcp_test_pkg::MODE_CLIENT, FIX);
        rd(8'h28, v); check(v, 32'h0);
        // Clean data, bad data with verify on, bad data with verify off
        for (int b = 0; b < 3; b++) begin
            wr(8'h2c, 32'h3);
            wr(8'h2c, (b == 2) ? 32'h0 : 32'h1);
            wr(8'h08, {30'h0, tcp_test_pkg::CMD_PASSIVE_OPEN});
            poll(8'h04, 32'h2, 32'h2);
            rx_send(8'd6, b != 0, 1'b1);
            poll(8'h04, 32'h2, 32'h0);
            rd(8'h30, v); check(v, 32'd24);
            rd(8'h34, v); check(v & 32'h100, (b == 1) ? 32'h100 : 32'h0);
        end
        for (int p = 0; p < 2; p++) begin // Repeated passes
            wr(8'h08, {30'h0, tcp_test_pkg::CMD_ACTIVE_OPEN});
            poll(8'h04, 32'h2, 32'h2);
            wr(8'h2c, 32'h3);
            wr(8'h2c, 32'h1);
            wr(8'h24, 32'h2);
            wr(8'h18, 32'd16);
            wr(8'h1c, 32'd8);
            wr(8'h20, 32'h0);
            rx_send(8'd4, 1'b0, 1'b0);
            wr(8'h24, 32'h1);
            poll(8'h28, 32'hffff_ffff, 32'd16);
            poll(8'h30, 32'hffff_ffff, 32'd16);
            check({24'h0, tx_bad}, 32'h0);
            check({24'h0, tx_push}, 32'd4);
            rd(8'h34, v); check(v & 32'h100, 32'h0);
            wr(8'h08, {30'h0, tcp_test_pkg::CMD_ACTIVE_CLOSE});
            poll(8'h04, 32'h2, 32'h0);
        end
        test_done();
    end
endmodule : testbench
